// ---- pkg/dbhp_pkg.sv ----
// Constants, types and helpers shared by the disk board host port
package dbhp_pkg;

    // ==========================================================
    // Host bus shape
    localparam int DW    = 8;
    localparam int SEL_W = 3;

    // ==========================================================
    // Register select codes
    localparam logic [2:0] SEL_DATA   = 3'h0;
    localparam logic [2:0] SEL_ERR_WP = 3'h1;  // Error on read, precomp on write
    localparam logic [2:0] SEL_COUNT  = 3'h2;
    localparam logic [2:0] SEL_SECTOR = 3'h3;
    localparam logic [2:0] SEL_CYL_LO = 3'h4;
    localparam logic [2:0] SEL_CYL_HI = 3'h5;
    localparam logic [2:0] SEL_SDH    = 3'h6;
    localparam logic [2:0] SEL_STAT   = 3'h7;  // Status on read, command on write

    // ==========================================================
    // Values after master reset
    localparam logic [7:0] RST_COUNT   = 8'h01;
    localparam logic [7:0] RST_SECTOR  = 8'h00;
    localparam logic [7:0] RST_CYL     = 8'h00;
    localparam logic [7:0] RST_SDH     = 8'h00;
    localparam logic [7:0] RST_PRECOMP = 8'h80;  // Cylinder 128
    localparam logic [3:0] RST_STEP    = 4'hF;   // 7.5 ms hard, 40 ms floppy

    // ==========================================================
    // Field positions
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_DRQ_BIT  = 3;
    localparam int SDH_SIZE_LSB  = 5;
    localparam logic [3:0] CMD_RESTORE_NIB = 4'h1;
    localparam logic [3:0] CMD_SEEK_NIB    = 4'h7;

    // ==========================================================
    // Sector buffer
    localparam int CNT_W     = 11;
    localparam int BUF_DEPTH = 1024;

    typedef enum logic [1:0] {
        XF_IDLE      = 2'b00,
        XF_TO_HOST   = 2'b01,
        XF_FROM_HOST = 2'b11
    } dbhp_xfer_t;

    // Sector size field of the size/drive/head register to a byte count
    function automatic logic [10:0] dbhp_sector_bytes(input logic [1:0] code);
        unique case (code)
            2'h0:    dbhp_sector_bytes = 11'h100;
            2'h1:    dbhp_sector_bytes = 11'h200;
            2'h2:    dbhp_sector_bytes = 11'h400;
            default: dbhp_sector_bytes = 11'h080;
        endcase
    endfunction

endpackage

// ---- verification/dbhp_host_model.sv ----
// Host processor model driving the board's parallel access port
`timescale 1ns/10ps
module dbhp_host_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Host bus
    input  wire logic [7:0] bus_i,
    output logic      [7:0] wdata_o,
    output logic            wdata_oe_o,
    output logic      [2:0] reg_select_o,
    output logic            board_sel_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    // Read results
    output logic            rd_valid_o,
    output logic      [7:0] rd_data_o
);
    // ====================
    // Idle bus
    initial begin
        wdata_o       = 8'h00;
        wdata_oe_o    = 1'b0;
        reg_select_o  = 3'h0;
        board_sel_n_o = 1'b1;
        rd_n_o        = 1'b1;
        wr_n_o        = 1'b1;
        rd_valid_o    = 1'b0;
        rd_data_o     = 8'h00;
    end

    // ====================
    // One byte access
    task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_select_o  = sel;
        board_sel_n_o = 1'b0;
        rd_n_o        = wr;
        wr_n_o        = !wr;
        wdata_o       = d;
        wdata_oe_o    = wr;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        if (!wr) begin
            rd_data_o  = bus_i;
            rd_valid_o = 1'b1;
        end
        // Select dropped after every byte
        board_sel_n_o = 1'b1;
        rd_n_o        = 1'b1;
        wr_n_o        = 1'b1;
        wdata_oe_o    = 1'b0;
        reg_select_o  = ~sel;
        @(negedge ref_clk_i);
        rd_valid_o = 1'b0;
    endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking testbench of the disk board host port
`timescale 1ns/10ps
module testbench;
    import dbhp_pkg::*;
    // ====================
    // Signals
    logic        ref_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        mr = 1'b0, busy = 1'b0, done = 1'b0, floppy = 1'b0;
    logic        full = 1'b0, fill = 1'b0, dwe = 1'b0;
    logic [6:0]  stat = 7'h00;
    logic [7:0]  err = 8'h00, dwd = 8'h00, last_dal = 8'h00;
    logic [9:0]  dad = 10'h000;
    logic [7:0]  d_out, cmd_byte, cnt, secn, size_drive_head_reg, pre, drd, h_d, rdat, v, base;
    logic [15:0] cyl;
    logic [3:0]  hd, fd;
    logic [2:0]  sel;
    logic        d_oe, irq, transfer_request, cmd_stb, bdone, h_oe, sel_n, rd_n, wr_n, rv;
    logic [7:0]  exp_reg [1:6];
    logic [7:0]  exp_q [$];
    int          n_fail = 0, tests_run = 0, n_cmd = 0, seed, n, n0;
    int          nb [4] = '{256, 512, 1024, 128};
    // Released lines show a changing pattern, not the last value
    wire  [7:0]  dal = d_oe ? d_out : (h_oe ? h_d : ~last_dal);

    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) last_dal <= dal;

    dbhp_host_port dbhp_host_port_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(1'b1), .board_master_reset_i(mr),
        .host_data_i(dal), .host_data_o(d_out), .host_data_oe_o(d_oe), .reg_select_i(sel),
        .board_sel_n_i(sel_n), .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
        .completion_interrupt_o(irq), .transfer_request_o(transfer_request), .busy_i(busy), .status_i(stat),
        .error_i(err), .cmd_done_i(done), .drive_is_floppy_i(floppy), .cmd_strobe_o(cmd_stb),
        .cmd_byte_o(cmd_byte), .sector_count_o(cnt), .sector_number_o(secn), .cylinder_o(cyl),
        .size_drive_head_reg_o(size_drive_head_reg), .precomp_cyl_o(pre), .hd_step_rate_o(hd), .fd_step_rate_o(fd),
        .drive_buf_full_i(full), .host_fill_req_i(fill), .buf_done_o(bdone), .drive_we_i(dwe),
        .drive_addr_i(dad), .drive_wdata_i(dwd), .drive_rdata_o(drd));

    dbhp_host_model host_model_inst (
        .ref_clk_i(ref_clk_i), .bus_i(dal), .wdata_o(h_d), .wdata_oe_o(h_oe), .reg_select_o(sel),
        .board_sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .rd_valid_o(rv), .rd_data_o(rdat));

    // ====================
    // Checking
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) chk("read_unexpected", 16'h1, 16'h0);
            else chk("read_data", {8'h00, rdat}, {8'h00, exp_q.pop_front()});
        end
        if (cmd_stb === 1'b1) n_cmd++;
    end

    // ====================
    // Host and drive side actions
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        host_model_inst.access(1'b1, s, d);
    endtask

    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        exp_q.push_back(e);
        host_model_inst.access(1'b0, s, 8'h00);
        chk("data_oe", {15'h0, d_oe}, 16'h0);
    endtask

    task automatic pulse_done();
        done = 1'b1;
        @(negedge ref_clk_i);
        done = 1'b0;
        chk("irq_set", {15'h0, irq}, 16'h1);
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 8 && bdone !== 1'b1; k++) @(negedge ref_clk_i);
        if (k == 8) begin
            chk("buf_done_timeout", 16'h1, 16'h0);
            finish_test();
        end
        chk("drq_drop", {15'h0, transfer_request}, 16'h0);
    endtask

    task automatic chk_rst();
        chk("count", {8'h00, cnt}, 16'h0001);
        chk("sector", {8'h00, secn}, 16'h0000);
        chk("cylinder", cyl, 16'h0000);
        chk("sdh", {8'h00, size_drive_head_reg}, 16'h0000);
        chk("hd_step", {12'h000, hd}, 16'h000F);
        chk("fd_step", {12'h000, fd}, 16'h000F);
        chk("precomp", {8'h00, pre}, 16'h0080);
        chk("irq", {15'h0, irq}, 16'h0);
        chk("drq", {15'h0, transfer_request}, 16'h0);
    endtask

    // ====================
    // Main sequence
    initial begin
        seed = 32'hec0a;
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        chk_rst();
        $display("test reset done");
        for (int k = 1; k <= 6; k++) begin
            v = $random(seed);
            exp_reg[k] = v;
            wr(k[2:0], v);
        end
        chk("precomp_wr", {8'h00, pre}, {8'h00, exp_reg[1]});
        chk("count_wr", {8'h00, cnt}, {8'h00, exp_reg[2]});
        chk("sector_wr", {8'h00, secn}, {8'h00, exp_reg[3]});
        chk("cyl_wr", cyl, {exp_reg[5], exp_reg[4]});
        chk("sdh_wr", {8'h00, size_drive_head_reg}, {8'h00, exp_reg[6]});
        for (int k = 2; k <= 6; k++) rd(k[2:0], exp_reg[k]);
        err = $random(seed);
        rd(3'h1, err);
        stat = $random(seed);
        rd(3'h7, {1'b0, stat[6:4], 1'b0, stat[2:0]});
        busy = 1'b1;
        rd(3'h7, 8'h80);
        busy = 1'b0;
        $display("test registers done");
        pulse_done();
        rd(3'h7, {1'b0, stat[6:4], 1'b0, stat[2:0]});
        chk("irq_status_clr", {15'h0, irq}, 16'h0);
        pulse_done();
        floppy = 1'b1;
        n0 = n_cmd;
        wr(3'h7, 8'h13);
        chk("irq_cmd_clr", {15'h0, irq}, 16'h0);
        chk("cmd_pulses", n_cmd[15:0], n0[15:0] + 16'h1);
        chk("cmd_byte", {8'h00, cmd_byte}, 16'h0013);
        floppy = 1'b0;
        wr(3'h7, 8'h75);
        chk("steps", {8'h00, hd, fd}, 16'h0053);
        $display("test commands done");
        for (int t = 0; t < 2; t++) begin
            v = t ? 8'h00 : 8'h60;
            n = nb[v[6:5]];
            wr(3'h6, v);
            base = $random(seed);
            for (int i = 0; i < n; i++) begin
                dwe = 1'b1;
                dad = i[9:0];
                dwd = base + i[7:0];
                @(negedge ref_clk_i);
            end
            dwe = 1'b0;
            chk("drq_before_full", {15'h0, transfer_request}, 16'h0);
            full = 1'b1;
            @(negedge ref_clk_i);
            full = 1'b0;
            chk("drq_read", {15'h0, transfer_request}, 16'h1);
            for (int i = 0; i < n; i++) begin
                if (i == n - 1) chk("drq_last", {15'h0, transfer_request}, 16'h1);
                rd(3'h0, base + i[7:0]);
            end
            wait_done();
            fill = 1'b1;
            @(negedge ref_clk_i);
            fill = 1'b0;
            chk("drq_fill", {15'h0, transfer_request}, 16'h1);
            for (int i = 0; i < n; i++) wr(3'h0, base ^ i[7:0]);
            wait_done();
            for (int a = 0; a < n; a += n - 1) begin
                dad = a[9:0];
                @(negedge ref_clk_i);
                chk("drive_read", {8'h00, drd}, {8'h00, base ^ a[7:0]});
            end
        end
        $display("test transfers done");
        pulse_done();
        full = 1'b1;
        @(negedge ref_clk_i);
        full = 1'b0;
        for (int i = 0; i < 3; i++) rd(3'h0, base ^ i[7:0]);
        mr = 1'b1;
        @(negedge ref_clk_i);
        mr = 1'b0;
        chk_rst();
        $display("test master reset done");
        finish_test();
    end
endmodule

// ---- verilog/dbhp_host_port.sv ----
// Host parallel port of the disk board: task file, sector buffer, TRANSFER_REQUEST, COMPLETION_INTERRUPT
`timescale 1ns/10ps
module dbhp_host_port
    import dbhp_pkg::*;
#(
    parameter int BUF_DEPTH_P = dbhp_pkg::BUF_DEPTH
) (
    // Clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   srst_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   board_master_reset_i,
    // Host bus
    input  wire logic [dbhp_pkg::DW-1:0]    host_data_i,
    output logic      [dbhp_pkg::DW-1:0]    host_data_o,
    output logic                        host_data_oe_o,
    input  wire logic [dbhp_pkg::SEL_W-1:0] reg_select_i,
    input  wire logic                   board_sel_n_i,
    input  wire logic                   host_read_strobe_n_i,
    input  wire logic                   host_write_strobe_n_i,
    output logic                        completion_interrupt_o,
    output logic                        transfer_request_o,
    // Controller side status
    input  wire logic                   busy_i,
    input  wire logic [6:0]             status_i,
    input  wire logic [7:0]             error_i,
    input  wire logic                   cmd_done_i,
    input  wire logic                   drive_is_floppy_i,
    // Controller side task file
    output logic                        cmd_strobe_o,
    output logic      [7:0]             cmd_byte_o,
    output logic      [7:0]             sector_count_o,
    output logic      [7:0]             sector_number_o,
    output logic      [15:0]            cylinder_o,
    output logic      [7:0]             size_drive_head_reg_o,
    output logic      [7:0]             precomp_cyl_o,
    output logic      [3:0]             hd_step_rate_o,
    output logic      [3:0]             fd_step_rate_o,
    // Controller side buffer handshake
    input  wire logic                   drive_buf_full_i,
    input  wire logic                   host_fill_req_i,
    output logic                        buf_done_o,
    input  wire logic                   drive_we_i,
    input  wire logic [9:0]             drive_addr_i,
    input  wire logic [7:0]             drive_wdata_i,
    output logic      [7:0]             drive_rdata_o
);
    import dbhp_pkg::*;

    if (BUF_DEPTH_P < 1024 || BUF_DEPTH_P > 1024) begin : g_chk
        $error("dbhp_host_port: buffer must hold exactly one 1024-byte sector");
    end

    // ==========================================================
    // Access framing
    logic       rst;
    logic       rd_act;
    logic       wr_act;
    logic       acc_act;
    logic       act_r;
    logic       act_nxt;
    logic       is_rd_r;
    logic       is_rd_nxt;
    logic [2:0] sel_r;
    logic [2:0] sel_nxt;
    logic       acc_start;
    logic       acc_end;
    logic       rd_start;
    logic       wr_start;

    assign rst       = srst_i | board_master_reset_i;
    assign rd_act    = !board_sel_n_i && !host_read_strobe_n_i;
    assign wr_act    = !board_sel_n_i && !host_write_strobe_n_i;
    assign acc_act   = rd_act || wr_act;
    assign acc_start = acc_act && !act_r;
    assign acc_end   = !acc_act && act_r;
    assign rd_start  = acc_start && rd_act;
    assign wr_start  = acc_start && !rd_act;

    always_comb begin
        act_nxt   = acc_act;
        is_rd_nxt = acc_start ? rd_act : is_rd_r;
        sel_nxt   = acc_start ? reg_select_i : sel_r;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            act_r   <= 1'b0;
            is_rd_r <= 1'b0;
            sel_r   <= SEL_DATA;
        end else if (clk_en_i) begin
            act_r   <= act_nxt;
            is_rd_r <= is_rd_nxt;
            sel_r   <= sel_nxt;
        end
    end

    // ==========================================================
    // Task file and interrupt
    logic [7:0]  count_r, count_nxt, sector_r, sector_nxt, sdh_r, sdh_nxt;
    logic [7:0]  wp_r, wp_nxt, cmd_r, cmd_nxt;
    logic [15:0] cyl_r, cyl_nxt;
    logic [3:0]  hd_step_r, hd_step_nxt, fd_step_r, fd_step_nxt;
    logic        cmd_stb_r, cmd_stb_nxt, irq_r, irq_nxt;

    always_comb begin
        count_nxt   = count_r;
        sector_nxt  = sector_r;
        sdh_nxt     = sdh_r;
        wp_nxt      = wp_r;
        cmd_nxt     = cmd_r;
        cyl_nxt     = cyl_r;
        hd_step_nxt = hd_step_r;
        fd_step_nxt = fd_step_r;
        cmd_stb_nxt = 1'b0;
        irq_nxt     = irq_r;
        if (wr_start) begin
            unique case (reg_select_i)
                SEL_ERR_WP: wp_nxt           = host_data_i;
                SEL_COUNT:  count_nxt        = host_data_i;
                SEL_SECTOR: sector_nxt       = host_data_i;
                SEL_CYL_LO: cyl_nxt[7:0]     = host_data_i;
                SEL_CYL_HI: cyl_nxt[15:8]    = host_data_i;
                SEL_SDH:    sdh_nxt          = host_data_i;
                SEL_STAT: begin
                    cmd_nxt     = host_data_i;
                    cmd_stb_nxt = 1'b1;
                    irq_nxt     = 1'b0;
                    // Restore and seek carry a new step rate for the selected drive kind
                    if (host_data_i[7:4] == CMD_RESTORE_NIB || host_data_i[7:4] == CMD_SEEK_NIB) begin
                        if (drive_is_floppy_i) begin
                            fd_step_nxt = host_data_i[3:0];
                        end else begin
                            hd_step_nxt = host_data_i[3:0];
                        end
                    end
                end
                SEL_DATA:   cmd_nxt          = cmd_r;
            endcase
        end
        if (rd_start && reg_select_i == SEL_STAT) begin
            irq_nxt = 1'b0;
        end
        if (cmd_done_i) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            count_r   <= RST_COUNT;
            sector_r  <= RST_SECTOR;
            cyl_r     <= {RST_CYL, RST_CYL};
            sdh_r     <= RST_SDH;
            hd_step_r <= RST_STEP;
            fd_step_r <= RST_STEP;
            wp_r      <= RST_PRECOMP;
            cmd_r     <= 8'h00;
            cmd_stb_r <= 1'b0;
            irq_r     <= 1'b0;
        end else if (clk_en_i) begin
            count_r   <= count_nxt;
            sector_r  <= sector_nxt;
            cyl_r     <= cyl_nxt;
            sdh_r     <= sdh_nxt;
            hd_step_r <= hd_step_nxt;
            fd_step_r <= fd_step_nxt;
            wp_r      <= wp_nxt;
            cmd_r     <= cmd_nxt;
            cmd_stb_r <= cmd_stb_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // ==========================================================
    // Buffer transfer sequencing
    dbhp_xfer_t  xf_r, xf_nxt;
    logic [10:0] cnt_r, cnt_nxt;
    logic [9:0]  ptr_r, ptr_nxt;
    logic        drq_r, drq_nxt, done_r, done_nxt;
    logic        data_end;
    logic        dir_ok;
    logic [7:0]  buf_rdata;

    assign data_end = acc_end && sel_r == SEL_DATA;
    assign dir_ok   = (xf_r == XF_TO_HOST) == is_rd_r;

    always_comb begin
        xf_nxt   = xf_r;
        cnt_nxt  = cnt_r;
        ptr_nxt  = ptr_r;
        done_nxt = 1'b0;
        // Pointer moves at the end of a byte so the byte stays put while it is read
        if (data_end) begin
            ptr_nxt = ptr_r + 10'h001;
        end
        unique case (xf_r)
            XF_IDLE: begin
                // Read data is offered only once the drive side filled the buffer
                if (drive_buf_full_i) begin
                    xf_nxt  = XF_TO_HOST;
                    cnt_nxt = dbhp_sector_bytes(sdh_r[SDH_SIZE_LSB +: 2]);
                    ptr_nxt = 10'h000;
                end else if (host_fill_req_i) begin
                    xf_nxt  = XF_FROM_HOST;
                    cnt_nxt = dbhp_sector_bytes(sdh_r[SDH_SIZE_LSB +: 2]);
                    ptr_nxt = 10'h000;
                end
            end
            XF_TO_HOST, XF_FROM_HOST: begin
                if (data_end && dir_ok) begin
                    cnt_nxt = cnt_r - 11'h001;
                    if (cnt_r == 11'h001) begin
                        xf_nxt   = XF_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
        endcase
        drq_nxt = xf_nxt != XF_IDLE;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            xf_r   <= XF_IDLE;
            cnt_r  <= 11'h000;
            ptr_r  <= 10'h000;
            drq_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (clk_en_i) begin
            xf_r   <= xf_nxt;
            cnt_r  <= cnt_nxt;
            ptr_r  <= ptr_nxt;
            drq_r  <= drq_nxt;
            done_r <= done_nxt;
        end
    end

    dbhp_sector_buf #(
        .DEPTH (BUF_DEPTH_P),
        .AW    (10)
    ) u_buf (
        .ref_clk_i (ref_clk_i),
        .clk_en_i  (clk_en_i),
        .h_we_i    (wr_start && reg_select_i == SEL_DATA),
        .h_addr_i  (ptr_r),
        .h_wdata_i (host_data_i),
        .h_rdata_o (buf_rdata),
        .d_we_i    (drive_we_i),
        .d_addr_i  (drive_addr_i),
        .d_wdata_i (drive_wdata_i),
        .d_rdata_o (drive_rdata_o)
    );

    // ==========================================================
    // Read path onto the shared data bus
    logic [7:0] stat_byte;
    logic [7:0] dout_r, dout_nxt;
    logic       oe_r, oe_nxt;

    always_comb begin
        stat_byte                = {busy_i, status_i};
        stat_byte[STAT_DRQ_BIT]  = drq_r;
        // While busy the other bits mean nothing, so show them as zero
        if (busy_i) begin
            stat_byte = 8'h00;
            stat_byte[STAT_BUSY_BIT] = 1'b1;
        end
        unique case (reg_select_i)
            SEL_DATA:   dout_nxt = buf_rdata;
            SEL_ERR_WP: dout_nxt = error_i;
            SEL_COUNT:  dout_nxt = count_r;
            SEL_SECTOR: dout_nxt = sector_r;
            SEL_CYL_LO: dout_nxt = cyl_r[7:0];
            SEL_CYL_HI: dout_nxt = cyl_r[15:8];
            SEL_SDH:    dout_nxt = sdh_r;
            SEL_STAT:   dout_nxt = stat_byte;
        endcase
        oe_nxt = rd_act;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst) begin
            dout_r <= 8'h00;
            oe_r   <= 1'b0;
        end else if (clk_en_i) begin
            dout_r <= dout_nxt;
            oe_r   <= oe_nxt;
        end
    end

    assign host_data_o            = dout_r;
    assign host_data_oe_o         = oe_r;
    assign completion_interrupt_o = irq_r;
    assign transfer_request_o     = drq_r;
    assign cmd_strobe_o           = cmd_stb_r;
    assign cmd_byte_o             = cmd_r;
    assign sector_count_o         = count_r;
    assign sector_number_o        = sector_r;
    assign cylinder_o             = cyl_r;
    assign size_drive_head_reg_o  = sdh_r;
    assign precomp_cyl_o          = wp_r;
    assign hd_step_rate_o         = hd_step_r;
    assign fd_step_rate_o         = fd_step_r;
    assign buf_done_o             = done_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst || !clk_en_i);

    sequence s_last_byte;
        drq_r && cnt_r == 11'h001 && data_end && dir_ok;
    endsequence

    a_release_no_sel: assert property (oe_r |-> $past(!board_sel_n_i))
        else $error("data bus driven without board select");
    a_read_drives_bus: assert property (rd_act |=> oe_r)
        else $error("read access not driven");
    a_count_write_taken: assert property (wr_start && reg_select_i == SEL_COUNT |=> count_r == $past(host_data_i))
        else $error("sector count write lost");
    a_done_sets_irq: assert property (cmd_done_i |=> irq_r)
        else $error("completion did not raise interrupt");
    a_cmd_clears_irq: assert property (wr_start && reg_select_i == SEL_STAT && !cmd_done_i |=> !irq_r)
        else $error("command write left interrupt set");
    a_full_raises_drq: assert property (xf_r == XF_IDLE && drive_buf_full_i |=> drq_r ##0 xf_r == XF_TO_HOST)
        else $error("full buffer did not raise request");
    a_last_drops_drq: assert property (s_last_byte |=> !drq_r && done_r)
        else $error("request not dropped after last byte");
    a_busy_masks_stat: assert property (busy_i |-> stat_byte == 8'h80)
        else $error("status bits visible while busy");
    a_stat_readable: assert property (rd_start && reg_select_i == SEL_STAT |=> dout_r == $past(stat_byte))
        else $error("status not presented on read");

endmodule

// ---- verilog/dbhp_sector_buf.sv ----
// Dual-port sector buffer: host port and drive port
`timescale 1ns/10ps
module dbhp_sector_buf #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    // Clock
    input  wire logic          ref_clk_i,
    input  wire logic          clk_en_i,
    // Host port, read is combinational
    input  wire logic          h_we_i,
    input  wire logic [AW-1:0] h_addr_i,
    input  wire logic [7:0]    h_wdata_i,
    output logic      [7:0]    h_rdata_o,
    // Drive port, read is registered
    input  wire logic          d_we_i,
    input  wire logic [AW-1:0] d_addr_i,
    input  wire logic [7:0]    d_wdata_i,
    output logic      [7:0]    d_rdata_o
);

    logic [7:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("dbhp_sector_buf: DEPTH exceeds address width");
    end

    assign h_rdata_o = mem[h_addr_i];

    // Host write wins a same-address collision; the drive side waits on buf_done_o
    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i) begin
            if (d_we_i && !(h_we_i && h_addr_i == d_addr_i)) begin
                mem[d_addr_i] <= d_wdata_i;
            end
            if (h_we_i) begin
                mem[h_addr_i] <= h_wdata_i;
            end
            d_rdata_o <= mem[d_addr_i];
        end
    end

endmodule
